/* File: hw/seep_defs.svh */
`ifndef SEEP_DEFS_SVH
`define SEEP_DEFS_SVH

`define SEEP_CLK_NS       10
`define SEEP_POR_US       100
`define SEEP_POR_CYC      ((`SEEP_POR_US * 1000 + `SEEP_CLK_NS - 1) / `SEEP_CLK_NS)
`define SEEP_TWR_MS       5
`define SEEP_TWR_CYC      ((`SEEP_TWR_MS * 1000000 + `SEEP_CLK_NS - 1) / `SEEP_CLK_NS)
`define SEEP_SCL_NS       10000
`define SEEP_QTR_CYC      (`SEEP_SCL_NS / (4 * `SEEP_CLK_NS))

`define SEEP_TYPE_ARRAY   4'ha
`define SEEP_TYPE_ID      4'hb
`define SEEP_ADDR_W       12
`define SEEP_PAGE_W       5
`define SEEP_BYTE_BITS    4'h8
`define SEEP_A10_BIT      2
`define SEEP_LOCK_BIT     1
`define SEEP_LOCK_AHI     8'h04
`define SEEP_LOCK_DATA    8'h02
`define SEEP_RESET_CLKS   4'h9
`define SEEP_FIFO_DEPTH   2

`endif

/* File: hw/seep_pkg.sv */
package seep_pkg;

  typedef enum logic [2:0] {
    T_POR,
    T_IDLE,
    T_DEV,
    T_AHI,
    T_ALO,
    T_DATA,
    T_READ
  } seep_tgt_state_type;

  typedef enum logic [2:0] {
    C_IDLE,
    C_START,
    C_BIT,
    C_WAIT,
    C_CLK9,
    C_STOP
  } seep_ctl_state_type;

  typedef enum logic [2:0] {
    OP_WRITE,
    OP_ID_WRITE,
    OP_LOCK,
    OP_POLL,
    OP_SOFT_RESET
  } seep_op_type;

endpackage

/* File: hw/seep_if.sv */
`timescale 1ns/1ps
interface seep_if;
  logic scl;
  logic ctl_sda_out;
  logic ctl_sda_oe;
  logic tgt_sda_out;
  logic tgt_sda_oe;
  logic sda;

  // open drain: any enabled low driver wins, else the pull-up
  assign sda = !((ctl_sda_oe && !ctl_sda_out) || (tgt_sda_oe && !tgt_sda_out));

  modport ctl (output scl, output ctl_sda_out, output ctl_sda_oe, input sda);
  modport tgt (input scl, input sda, output tgt_sda_out, output tgt_sda_oe);
endinterface

/* File: hw/seep_target.sv */
`timescale 1ns/1ps
`include "seep_defs.svh"
// Functional notes
// - sda change with scl high is start/stop
// - sda falling, scl high: start
// - sda rising, scl high: stop
// - msb-first bytes, ack on ninth clock
// - ignore everything until power-up delay ends
// - standby after power-up, read stop, write
// - start, nine clocks, start, stop recovers
// - address byte: type nibble, selects, rw
// - select mismatch: no ack, back to standby
// - rw bit one reads, zero writes; here a read only acks the address byte, no data is driven
// - write protect pin blocks all writes
// - byte write: device, two address, data
// - stop starts timed cycle, inputs ignored
// - page write keeps taking acked bytes
// - low five address bits wrap in page
// - polling acked only after cycle ends
// - id page write: type b, A11:A10 zero
// - locked id page: data not acked
// - lock command permanently locks id page
module seep_target
  import seep_pkg::*;
#(
  parameter int POR_CYCLES = `SEEP_POR_CYC,
  parameter int TWR_CYCLES = `SEEP_TWR_CYC,
  parameter int DEPTH      = `SEEP_FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  seep_if.tgt              bus,
  input  wire logic        chip_select_pin_high_in,
  input  wire logic        chip_select_pin_mid_in,
  input  wire logic        chip_select_pin_low_in,
  input  wire logic        write_protect_in,
  output logic             wr_valid_out,
  input  wire logic        wr_ready_in,
  output logic [11:0]      wr_addr_out,
  output logic [7:0]       wr_data_out,
  output logic             wr_id_page_out,
  output logic             id_locked_out,
  output logic             busy_out
);

  localparam int POR_W = $clog2(POR_CYCLES + 1);
  localparam int TWR_W = $clog2(TWR_CYCLES + 1);
  localparam int PTR_W = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int ENT_W = 1 + `SEEP_ADDR_W + 8;

  seep_tgt_state_type st;
  seep_tgt_state_type next_st;
  logic [2:0]         scl_sync;
  logic [2:0]         sda_sync;
  logic [3:0]         pin_meta;
  logic [3:0]         pin_sync;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;
  logic               byte_end;
  logic [7:0]         shreg;
  logic [3:0]         bitcnt;
  logic               ack_ph;
  logic               sda_oe;
  logic [7:0]         ahi;
  logic [11:0]        addr;
  logic               id_sel;
  logic               pend;
  logic               lock_pend;
  logic               id_locked;
  logic               next_ack;
  logic               push;
  logic               dev_ok;
  logic               wp;
  logic               lock_mode;
  logic               idw_mode;
  logic [POR_W-1:0]   por_cnt;
  logic               por_done;
  logic [TWR_W-1:0]   tmr;
  logic               busy;
  logic               cycle_start;
  logic [ENT_W-1:0]   fifo_mem [DEPTH];
  logic [PTR_W-1:0]   wr_ptr;
  logic [PTR_W-1:0]   rd_ptr;
  logic [PTR_W:0]     fifo_cnt;
  logic               fifo_in_ready;
  logic               fifo_pop;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second

  always_ff @(posedge clk_in) begin
    scl_sync <= {scl_sync[1:0], bus.scl};
    sda_sync <= {sda_sync[1:0], bus.sda};
    pin_meta <= {write_protect_in, chip_select_pin_high_in,
                 chip_select_pin_mid_in, chip_select_pin_low_in};
    pin_sync <= pin_meta;
  end

  assign scl_rise  = scl_sync[1] && !scl_sync[2];
  assign scl_fall  = !scl_sync[1] && scl_sync[2];
  assign start_det = scl_sync[1] && scl_sync[2] && sda_sync[2] && !sda_sync[1];
  assign stop_det  = scl_sync[1] && scl_sync[2] && !sda_sync[2] && sda_sync[1];
  assign byte_end  = scl_fall && !ack_ph && (bitcnt == `SEEP_BYTE_BITS);
  assign wp        = pin_sync[3];

  ////////////////////////////////////////////////////////////////////////////
  // power-up hold-off

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      por_cnt  <= '0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt  <= por_cnt + 1'b1;
      por_done <= (por_cnt == POR_W'(POR_CYCLES - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte decode and acknowledge decision

  assign dev_ok    = !busy && (shreg[3:1] == pin_sync[2:0]) &&
                     (shreg[7:4] == `SEEP_TYPE_ARRAY || shreg[7:4] == `SEEP_TYPE_ID);
  assign lock_mode = id_sel && ahi[`SEEP_A10_BIT];
  assign idw_mode  = id_sel && (ahi[3:2] == 2'b00);

  always_comb begin
    next_ack = 1'b0;
    next_st  = T_IDLE;
    push     = 1'b0;
    case (st)
      T_DEV: begin
        if (dev_ok) begin
          next_ack = 1'b1;
          next_st  = shreg[0] ? T_READ : T_AHI;
        end
      end
      T_AHI: begin
        next_ack = 1'b1;
        next_st  = T_ALO;
      end
      T_ALO: begin
        next_ack = 1'b1;
        next_st  = T_DATA;
      end
      T_DATA: begin
        next_st = T_DATA;
        if (lock_mode) begin
          next_ack = !id_locked;
        end else if (idw_mode) begin
          next_ack = !id_locked && (wp || fifo_in_ready);
          push     = !id_locked && !wp && fifo_in_ready;
        end else if (!id_sel) begin
          next_ack = wp || fifo_in_ready;
          push     = !wp && fifo_in_ready;
        end
      end
      T_READ: begin
        next_st = T_READ;
      end
      default: begin
        next_st = T_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st        <= T_POR;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      ack_ph    <= 1'b0;
      sda_oe    <= 1'b0;
      ahi       <= 8'h00;
      addr      <= 12'h000;
      id_sel    <= 1'b0;
      pend      <= 1'b0;
      lock_pend <= 1'b0;
      id_locked <= 1'b0;
    end else if (st == T_POR) begin
      if (por_done) begin
        st <= T_IDLE;
      end
    end else if (start_det) begin
      // a start anywhere restarts address reception, which is what clears a hung bus
      st     <= T_DEV;
      bitcnt <= 4'h0;
      ack_ph <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      st        <= T_IDLE;
      bitcnt    <= 4'h0;
      ack_ph    <= 1'b0;
      sda_oe    <= 1'b0;
      pend      <= 1'b0;
      lock_pend <= 1'b0;
      if (lock_pend) begin
        id_locked <= 1'b1;
      end
    end else if (scl_rise && !ack_ph && st != T_IDLE && bitcnt != `SEEP_BYTE_BITS) begin
      shreg  <= {shreg[6:0], sda_sync[1]};
      bitcnt <= bitcnt + 4'h1;
    end else if (scl_fall && ack_ph) begin
      ack_ph <= 1'b0;
      sda_oe <= 1'b0;
      bitcnt <= 4'h0;
    end else if (byte_end) begin
      ack_ph <= 1'b1;
      sda_oe <= next_ack;
      st     <= next_st;
      case (st)
        T_DEV: id_sel <= (shreg[7:4] == `SEEP_TYPE_ID);
        T_AHI: ahi <= shreg;
        T_ALO: addr <= {ahi[3:0], shreg};
        T_DATA: begin
          if (next_ack && !lock_mode) begin
            addr[`SEEP_PAGE_W-1:0] <= addr[`SEEP_PAGE_W-1:0] + 1'b1;
          end
          if (push) begin
            pend <= 1'b1;
          end
          if (lock_mode && !id_locked && !wp && shreg[`SEEP_LOCK_BIT]) begin
            lock_pend <= 1'b1;
            pend      <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed write cycle; also waits for the buffer to drain

  // only writes taken into the buffer, array or id page, or an accepted lock start a cycle
  assign cycle_start = stop_det && pend && st != T_POR;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy <= 1'b0;
      tmr  <= '0;
    end else if (cycle_start) begin
      busy <= 1'b1;
      tmr  <= TWR_W'(TWR_CYCLES - 1);
    end else if (busy) begin
      if (tmr != '0) begin
        tmr <= tmr - 1'b1;
      end else if (fifo_cnt == '0) begin
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write buffer toward the storage

  assign fifo_in_ready = (fifo_cnt != (PTR_W + 1)'(DEPTH));
  assign fifo_pop      = wr_valid_out && wr_ready_in;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fifo_cnt <= '0;
    end else begin
      if (byte_end && push) begin
        fifo_mem[wr_ptr] <= {id_sel, addr, shreg};
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      fifo_cnt <= fifo_cnt + (PTR_W + 1)'(byte_end && push) - (PTR_W + 1)'(fifo_pop);
    end
  end

  assign wr_valid_out                 = (fifo_cnt != '0);
  assign {wr_id_page_out, wr_addr_out, wr_data_out} = fifo_mem[rd_ptr];
  assign id_locked_out                = id_locked;
  assign busy_out                     = busy;
  assign bus.tgt_sda_out              = 1'b0;
  assign bus.tgt_sda_oe               = sda_oe;

endmodule

/* File: hw/seep_ctl.sv */
`timescale 1ns/1ps
`include "seep_defs.svh"
module seep_ctl
  import seep_pkg::*;
#(
  parameter int QTR_CYCLES = `SEEP_QTR_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  seep_if.ctl              bus,
  input  wire logic        cmd_valid_in,
  output logic             cmd_ready_out,
  input  wire seep_op_type cmd_op_in,
  input  wire logic [2:0]  cmd_sel_in,
  input  wire logic [11:0] cmd_addr_in,
  input  wire logic        tx_valid_in,
  output logic             tx_ready_out,
  input  wire logic [7:0]  tx_data_in,
  input  wire logic        tx_last_in,
  output logic             done_out,
  output logic             nack_out
);

  localparam int QW = $clog2(QTR_CYCLES + 1);

  seep_ctl_state_type st;
  seep_op_type        op;
  logic [2:0]         sel;
  logic [11:0]        addr;
  logic [QW-1:0]      qcnt;
  logic               tick;
  logic [1:0]         ph;
  logic [3:0]         bitcnt;
  logic [1:0]         idx;
  logic [7:0]         sh;
  logic               last;
  logic               again;
  logic               got_ack;
  logic               scl;
  logic               sda_oe;
  logic [1:0]         sda_sync;

  function automatic logic [7:0] seep_byte(input logic [1:0] i, input seep_op_type o,
                                           input logic [2:0] s, input logic [11:0] a);
    logic id;
    id = (o == OP_ID_WRITE || o == OP_LOCK);
    case (i)
      2'h0: seep_byte = {id ? `SEEP_TYPE_ID : `SEEP_TYPE_ARRAY, s, 1'b0};
      2'h1: seep_byte = (o == OP_LOCK) ? `SEEP_LOCK_AHI :
                        (o == OP_ID_WRITE) ? {6'h00, a[9:8]} : {4'h0, a[11:8]};
      2'h2: seep_byte = a[7:0];
      default: seep_byte = `SEEP_LOCK_DATA;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sampling and quarter-bit timer

  always_ff @(posedge clk_in) begin
    sda_sync <= {sda_sync[0], bus.sda};
  end

  assign tick = (qcnt == QW'(QTR_CYCLES - 1));

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || st == C_IDLE || st == C_WAIT) begin
      qcnt <= '0;
    end else begin
      qcnt <= tick ? '0 : qcnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus sequencer; sda only moves in phase 0 with scl low, except start/stop and the release as scl falls after the eighth bit

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st       <= C_IDLE;
      op       <= OP_WRITE;
      sel      <= 3'h0;
      addr     <= 12'h000;
      ph       <= 2'h0;
      bitcnt   <= 4'h0;
      idx      <= 2'h0;
      sh       <= 8'h00;
      last     <= 1'b0;
      again    <= 1'b0;
      got_ack  <= 1'b0;
      scl      <= 1'b1;
      sda_oe   <= 1'b0;
      done_out <= 1'b0;
      nack_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (st)
        C_IDLE: begin
          if (cmd_valid_in) begin
            op       <= cmd_op_in;
            sel      <= cmd_sel_in;
            addr     <= cmd_addr_in;
            last     <= (cmd_op_in == OP_LOCK);
            nack_out <= 1'b0;
            idx      <= 2'h0;
            again    <= 1'b0;
            ph       <= 2'h0;
            st       <= C_START;
          end
        end
        C_START: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: begin
              sda_oe <= 1'b0;
              scl    <= 1'b0;
            end
            2'h1: scl <= 1'b1;
            2'h2: sda_oe <= 1'b1;
            default: begin
              scl    <= 1'b0;
              bitcnt <= 4'h0;
              if (op == OP_SOFT_RESET && again) begin
                st <= C_STOP;
              end else if (op == OP_SOFT_RESET) begin
                st <= C_CLK9;
              end else begin
                sh <= seep_byte(2'h0, op, sel, addr);
                st <= C_BIT;
              end
            end
          endcase
        end
        C_BIT: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: begin
              scl    <= 1'b0;
              sda_oe <= (bitcnt != `SEEP_BYTE_BITS) && !sh[7];
            end
            2'h1: scl <= 1'b1;
            2'h2: if (bitcnt == `SEEP_BYTE_BITS) got_ack <= !sda_sync[1];
            default: begin
              scl <= 1'b0;
              if (bitcnt != `SEEP_BYTE_BITS) begin
                sh     <= {sh[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
                if (bitcnt == `SEEP_BYTE_BITS - 4'h1) begin
                  // let go as scl falls: the target pulls its ack a few cycles later
                  sda_oe <= 1'b0;
                end
              end else begin
                bitcnt <= 4'h0;
                if (!got_ack) begin
                  nack_out <= 1'b1;
                  st       <= C_STOP;
                end else if (op == OP_POLL || (idx == 2'h3 && last)) begin
                  st <= C_STOP;
                end else if ((idx == 2'h2 || idx == 2'h3) && op != OP_LOCK) begin
                  idx <= 2'h3;
                  st  <= C_WAIT;
                end else begin
                  idx <= idx + 2'h1;
                  sh  <= seep_byte(idx + 2'h1, op, sel, addr);
                end
              end
            end
          endcase
        end
        C_WAIT: begin
          // scl held low while the data source stalls
          if (tx_valid_in) begin
            sh   <= tx_data_in;
            last <= tx_last_in;
            ph   <= 2'h0;
            st   <= C_BIT;
          end
        end
        C_CLK9: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: begin
              scl    <= 1'b0;
              sda_oe <= 1'b0;
            end
            2'h1: scl <= 1'b1;
            2'h2: ;
            default: begin
              scl    <= 1'b0;
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == `SEEP_RESET_CLKS - 4'h1) begin
                again <= 1'b1;
                st    <= C_START;
              end
            end
          endcase
        end
        C_STOP: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: begin
              scl    <= 1'b0;
              sda_oe <= 1'b1;
            end
            2'h1: scl <= 1'b1;
            2'h2: sda_oe <= 1'b0;
            default: begin
              done_out <= 1'b1;
              st       <= C_IDLE;
            end
          endcase
        end
        default: st <= C_IDLE;
      endcase
    end
  end

  assign cmd_ready_out   = (st == C_IDLE);
  assign tx_ready_out    = (st == C_WAIT);
  assign bus.scl         = scl;
  assign bus.ctl_sda_out = 1'b0;
  assign bus.ctl_sda_oe  = sda_oe;

endmodule

/* File: sim/seep_properties.sv */
`timescale 1ns/1ps
module seep_properties #(
  parameter int POR_CYCLES = 20
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic scl,
  input  wire logic ctl_sda_out,
  input  wire logic ctl_sda_oe,
  input  wire logic tgt_sda_out,
  input  wire logic tgt_sda_oe,
  input  wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] rises;
  int         por_cnt;

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  always_ff @(posedge clk_in) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // rises since the last start; slot nine is the ack slot
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rises <= 4'h0;
    end else if (scl_q && scl && sda_q && !sda) begin
      rises <= 4'h0;
    end else if (!scl_q && scl) begin
      rises <= (rises == 4'h9) ? 4'h1 : rises + 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      por_cnt <= 0;
    end else if (por_cnt < POR_CYCLES) begin
      por_cnt <= por_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  tgt_edge_a: assert property ($changed(tgt_sda_oe) |-> !scl)
    else $error("target changed sda while scl high");
  start_form_a: assert property ($rose(ctl_sda_oe) && scl |->
    !sda throughout (##[1:20] $fell(scl))) else $error("start not held");
  stop_idle_a: assert property ($fell(ctl_sda_oe) && scl |->
    ##1 (scl && sda)[*4]) else $error("bus not idle after stop");
  ack_slot_a: assert property (tgt_sda_oe && scl && $past(scl) |->
    rises == 4'h9) else $error("ack outside ninth clock");
  ack_hold_a: assert property ($rose(tgt_sda_oe) |->
    tgt_sda_oe throughout (##[1:60] $fell(scl))) else $error("ack dropped early");
  ack_release_a: assert property ($fell(scl) && tgt_sda_oe |->
    ##[1:6] !tgt_sda_oe) else $error("ack not released");
  ack_low_a: assert property (tgt_sda_oe |-> !tgt_sda_out && !sda)
    else $error("ack does not pull sda low");
  sole_driver_a: assert property (tgt_sda_oe |-> !ctl_sda_oe)
    else $error("both ends drive sda");
  ctl_low_a: assert property (ctl_sda_oe |-> !ctl_sda_out && !sda)
    else $error("controller does not pull sda low");
  por_quiet_a: assert property (tgt_sda_oe |-> por_cnt == POR_CYCLES)
    else $error("ack during power-up hold-off");
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench import seep_pkg::*;;
  localparam int POR = 20;
  localparam int TWR = 1500;
  logic        clk_in, sys_rst_in, wp, wr_valid, wr_ready, wr_id, id_locked, busy, stall;
  logic        cmd_valid, cmd_ready, tx_valid, tx_ready, tx_last, done, nack;
  logic [2:0]  pins, cmd_sel;
  logic [11:0] wr_addr, cmd_addr;
  logic [7:0]  wr_data, tx_data;
  logic [7:0]  txb [0:35];
  logic [20:0] exp_e [$];
  int          exp_n [$];
  seep_op_type cmd_op;
  int          mismatches, check_count, seed, s, e_n;

  seep_if bus_if ();
  seep_target #(.POR_CYCLES(POR), .TWR_CYCLES(TWR), .DEPTH(2)) u_seep_target (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(bus_if),
    .chip_select_pin_high_in(pins[2]), .chip_select_pin_mid_in(pins[1]),
    .chip_select_pin_low_in(pins[0]), .write_protect_in(wp), .wr_valid_out(wr_valid),
    .wr_ready_in(wr_ready), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .wr_id_page_out(wr_id), .id_locked_out(id_locked), .busy_out(busy));
  seep_ctl #(.QTR_CYCLES(8)) u_seep_ctl (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(bus_if), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_sel_in(cmd_sel),
    .cmd_addr_in(cmd_addr), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .tx_data_in(tx_data), .tx_last_in(tx_last), .done_out(done), .nack_out(nack));
  seep_properties #(.POR_CYCLES(POR)) chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl(bus_if.scl),
    .ctl_sda_out(bus_if.ctl_sda_out), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .tgt_sda_out(bus_if.tgt_sda_out), .tgt_sda_oe(bus_if.tgt_sda_oe), .sda(bus_if.sda));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic timed_out(input string what);
    mismatches++;
    $display("mismatch %s expected handshake seen timeout", what);
    conclude();
  endtask

  task automatic chk_flag(input string name, input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_entry(input logic [20:0] got, input logic [20:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch entry expected %h seen %h", exp, got);
    end
  endtask

  // expected entries: only the low five address bits move, wrapping in the page
  task automatic exp_page(input logic [11:0] a, input int n, input logic id);
    for (int i = 0; i < n; i++) exp_e.push_back({id, a[11:5], 5'(a[4:0] + i[4:0]), txb[i]});
  endtask

  task automatic do_cmd(input seep_op_type op, input logic [2:0] sel, input logic [11:0] a,
                        input int n, input int en);
    int k;
    exp_n.push_back(en);
    @(negedge clk_in);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_sel = sel;
    cmd_addr = a;
    k = 0;
    do begin @(posedge clk_in); k++; end while (cmd_ready !== 1'b1 && k < 100);
    if (k >= 100) timed_out("cmd_ready");
    @(negedge clk_in);
    cmd_valid = 1'b0;
    // valid stays up between bytes so it is never lowered and raised at once
    for (int i = 0; i < n; i++) begin
      tx_valid = 1'b1;
      tx_data = txb[i];
      tx_last = (i == n - 1);
      k = 0;
      do begin @(posedge clk_in); k++; end while (tx_ready !== 1'b1 && k < 2000);
      if (k >= 2000) timed_out("tx_ready");
      @(negedge clk_in);
    end
    tx_valid = 1'b0;
    k = 0;
    do begin @(posedge clk_in); k++; end while (done !== 1'b1 && k < 20000);
    if (k >= 20000) timed_out("done");
    repeat (4) @(negedge clk_in);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin @(posedge clk_in); k++; end while (busy !== 1'b0 && k < 4000);
    if (k >= 4000) timed_out("busy");
    @(negedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_in) wr_ready <= stall ? 1'b0 : 1'($random(seed));

  // results are matched against the oldest note the driver left
  always @(posedge clk_in) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_e.size() == 0) chk_entry({wr_id, wr_addr, wr_data}, 21'bx);
      else chk_entry({wr_id, wr_addr, wr_data}, exp_e.pop_front());
    end
    if (done === 1'b1 && exp_n.size() != 0) begin
      e_n = exp_n.pop_front();
      if (e_n >= 0) chk_flag("nack", nack, e_n[0]);
    end
  end

  initial begin
    seed = 98;
    {sys_rst_in, wp, stall, cmd_valid, tx_valid, tx_last} = 6'h20;
    cmd_op = OP_POLL;
    {cmd_sel, cmd_addr, tx_data} = 23'h0;
    pins = 3'($random(seed));
    for (int i = 0; i < 36; i++) txb[i] = 8'($random(seed));
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (POR + 3) @(negedge clk_in);
    for (s = 0; s < 8; s++) do_cmd(OP_POLL, 3'(s), 12'h000, 0, int'(3'(s) != pins));
    $display("test select done");
    exp_page(12'h7a3, 1, 1'b0);
    do_cmd(OP_WRITE, pins, 12'h7a3, 1, 0);
    chk_flag("busy", busy, 1'b1);
    do_cmd(OP_POLL, pins, 12'h000, 0, 1);
    wait_idle();
    do_cmd(OP_POLL, pins, 12'h000, 0, 0);
    $display("test byte write done");
    exp_page(12'h3fc, 34, 1'b0);
    do_cmd(OP_WRITE, pins, 12'h3fc, 34, 0);
    wait_idle();
    stall = 1'b1;
    exp_page(12'h100, 2, 1'b0);
    do_cmd(OP_WRITE, pins, 12'h100, 3, 1);
    stall = 1'b0;
    wait_idle();
    $display("test page write done");
    wp = 1'b1;
    do_cmd(OP_WRITE, pins, 12'h055, 2, 0);
    chk_flag("busy", busy, 1'b0);
    do_cmd(OP_POLL, pins, 12'h000, 0, 0);
    wp = 1'b0;
    $display("test write protect done");
    exp_page(12'h01e, 3, 1'b1);
    do_cmd(OP_ID_WRITE, pins, 12'h01e, 3, 0);
    wait_idle();
    do_cmd(OP_LOCK, pins, 12'h400, 0, 0);
    chk_flag("locked", id_locked, 1'b1);
    wait_idle();
    do_cmd(OP_ID_WRITE, pins, 12'h000, 1, 1);
    wait_idle();
    do_cmd(OP_LOCK, pins, 12'h400, 0, 1);
    wait_idle();
    $display("test id page done");
    do_cmd(OP_SOFT_RESET, pins, 12'h000, 0, -1);
    do_cmd(OP_POLL, pins, 12'h000, 0, 0);
    $display("test soft reset done");
    repeat (20) @(negedge clk_in);
    chk_flag("entries left", exp_e.size() == 0, 1'b1);
    conclude();
  end
endmodule
